// ### design/evt_latch_pkg.sv
package evt_latch_pkg;

  // Register byte offsets
  localparam logic [7:0] SET_PORT_OFF   = 8'h80;
  localparam logic [7:0] CLEAR_PORT_OFF = 8'h84;
  localparam logic [7:0] MASK_OFF       = 8'h88;
  localparam logic [7:0] CTRL_OFF       = 8'h8C;
  localparam logic [7:0] TIMER_OFF      = 8'h90;
  localparam logic [7:0] PHY_DATA_OFF   = 8'h94;

  // Event bit positions
  localparam int SOFT_BIT    = 29;
  localparam int LATE_BIT    = 27;
  localparam int PHY_BIT     = 26;
  localparam int OVERLONG_BIT = 25;
  localparam int FATAL_BIT   = 24;
  localparam int MISMATCH_BIT = 23;
  localparam int MISSED_BIT  = 22;
  localparam int SIXTYFOUR_BIT = 21;
  localparam int PSTART_BIT  = 20;

  // Writable/valid event positions: bits 29, 27..20
  localparam logic [31:0] VALID_MASK = 32'h2FF0_0000;
  // Bits zero after reset: 31,29,28,27,18,15..12
  localparam logic [31:0] EVENT_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET  = 32'h0000_0000;

  // Control register bits
  localparam int CTRL_LATE_ACK_BIT   = 0;
  localparam int CTRL_TIMING_ROOT_BIT = 1;

  // Overlong cycle limit
  localparam int  CLK_HZ          = 20_000_000;
  localparam int  OVERLONG_US     = 125;
  localparam int  OVERLONG_CYCLES = (OVERLONG_US * (CLK_HZ / 1_000_000));

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic        rx_fifo_pending;
    logic        phys_resp_busy;
    logic        late_ack_sent;
    logic        phy_byte_strobe;
    logic [7:0]  phy_byte;
    logic        cycle_start_tx;
    logic        subaction_gap;
    logic        context_dead;
    logic        cycle_start_rx;
    logic [6:0]  rx_seconds;
    logic [12:0] rx_count;
    logic        arb_reset_gap;
    logic [6:0]  seconds_field;
    logic [12:0] period_count_field;
  } evt_src_t;

endpackage

// ### design/serial_bus_interrupt_event_latch.sv
// Behaviour
// [R1] Event bit sets on source rising edge or a one written to set port; bits 21 and 20 set on either edge of their source.
// [R2] Event bit clears only by a one written to clear port.
// [R3] Reads of set or clear port return events ANDed with mask.
// [R4] Bits 31, 30, 28 read zero and ignore writes.
// [R5] Bit 29 is software-only, set and cleared through the ports.
// [R6] With late_ack_enable, bit 27 sets on FIFO data, busy, or late ack.
// [R7] Bit 26 sets when a PHY byte arrives; byte readable in bits 23..16.
// [R8] With timing_root_enable, bit 25 sets if cycle start to gap exceeds 125us.
// [R9] Overlong cycle event clears timing_root_enable.
// [R10] Bit 24 sets when a context goes dead and stops.
// [R11] While bit 24 is set, that context's normal events are blocked.
// [R12] Bit 23 sets when received cycle start disagrees with local timer.
// [R13] Bit 22 sets if no cycle start between two period starts.
// [R14] Bit 22 may set early on a predicted lost cycle.
// [R15] Bit 21 sets when seconds counter bit six changes.
// [R16] Bit 20 sets when period count low bit toggles.
// [R17] After reset bits 31,29,28,27,18,15..12 are zero.
// [R18] Writing zero to a port bit leaves the event unchanged.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module serial_bus_interrupt_event_latch #(
  parameter int OVERLONG_LIMIT = evt_latch_pkg::OVERLONG_CYCLES
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire evt_latch_pkg::evt_src_t src,
  output logic                         irq
);

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [31:0] events;
    logic [31:0] mask;
    logic        late_ack_en;
    logic        timing_root;
    logic [7:0]  phy_byte;
    logic        late_src_d;
    logic        phy_d;
    logic        dead_d;
    logic        sec6_d;
    logic        cnt0_d;
    logic        timing_run;
    logic [15:0] cyc_cnt;
    logic        seen_start;
    logic        synch_seen;
    logic        gap_after;
    logic        irq;
  } st_t;

  st_t st_ff;
  st_t nxt_st;

  logic [31:0] rd_val;
  logic [31:0] hw_set;
  logic [31:0] wr_mask;
  logic        late_src;
  logic        blocked;
  logic        cnt_edge;
  logic        do_wr;

  always_comb
  begin
    nxt_st = st_ff;
    hw_set = 32'h0000_0000;
    wr_mask = 32'h0000_0000;
    rd_val = 32'h0000_0000;
    do_wr = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      wr_mask[i*8 +: 8] = {8{st_ff.wstrb[i]}};
    end
    blocked = st_ff.events[evt_latch_pkg::FATAL_BIT]; // R11
    late_src = src.rx_fifo_pending | src.phys_resp_busy | src.late_ack_sent;
    cnt_edge = src.period_count_field[0] ^ st_ff.cnt0_d;

    // Write channel
    nxt_st.awready = 1'b0;
    nxt_st.wready = 1'b0;
    if (s_axi_awvalid && !st_ff.aw_got && !st_ff.bvalid && !st_ff.awready)
    begin
      nxt_st.awready = 1'b1;
    end
    if (s_axi_wvalid && !st_ff.w_got && !st_ff.bvalid && !st_ff.wready)
    begin
      nxt_st.wready = 1'b1;
    end
    if (st_ff.awready && s_axi_awvalid)
    begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (st_ff.wready && s_axi_wvalid)
    begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid)
    begin
      do_wr = 1'b1;
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = evt_latch_pkg::RESP_OKAY;
      case ({st_ff.awaddr[7:2], 2'b00})
        evt_latch_pkg::SET_PORT_OFF,
        evt_latch_pkg::CLEAR_PORT_OFF,
        evt_latch_pkg::MASK_OFF,
        evt_latch_pkg::CTRL_OFF:
        begin
          nxt_st.bresp = evt_latch_pkg::RESP_OKAY;
        end
        default:
        begin
          nxt_st.bresp = evt_latch_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st_ff.bvalid && s_axi_bready)
    begin
      nxt_st.bvalid = 1'b0;
    end

    // Hardware event sources
    if (st_ff.late_ack_en && late_src && !st_ff.late_src_d && !blocked)
    begin
      hw_set[evt_latch_pkg::LATE_BIT] = 1'b1; // R6
    end
    nxt_st.late_src_d = late_src;
    if (src.phy_byte_strobe && !st_ff.phy_d)
    begin
      hw_set[evt_latch_pkg::PHY_BIT] = 1'b1; // R7
      nxt_st.phy_byte = src.phy_byte;
    end
    nxt_st.phy_d = src.phy_byte_strobe;
    if (src.context_dead && !st_ff.dead_d)
    begin
      hw_set[evt_latch_pkg::FATAL_BIT] = 1'b1; // R10
    end
    nxt_st.dead_d = src.context_dead;
    if (src.cycle_start_rx && !blocked &&
        (src.rx_seconds != src.seconds_field ||
         src.rx_count != src.period_count_field))
    begin
      hw_set[evt_latch_pkg::MISMATCH_BIT] = 1'b1; // R12
    end
    if (src.seconds_field[6] != st_ff.sec6_d)
    begin
      hw_set[evt_latch_pkg::SIXTYFOUR_BIT] = 1'b1; // R15
    end
    nxt_st.sec6_d = src.seconds_field[6];
    if (cnt_edge)
    begin
      hw_set[evt_latch_pkg::PSTART_BIT] = 1'b1; // R16
    end
    nxt_st.cnt0_d = src.period_count_field[0];

    // Lost cycle tracking
    if (src.cycle_start_tx || src.cycle_start_rx)
    begin
      nxt_st.seen_start = 1'b1;
    end
    if (src.subaction_gap && st_ff.synch_seen && !st_ff.seen_start)
    begin
      nxt_st.gap_after = 1'b1;
    end
    if (st_ff.synch_seen && !st_ff.seen_start &&
        (src.arb_reset_gap ||
         (st_ff.gap_after && src.cycle_start_rx)))
    begin
      hw_set[evt_latch_pkg::MISSED_BIT] = 1'b1; // R14
    end
    if (cnt_edge)
    begin
      if (st_ff.synch_seen && !st_ff.seen_start)
      begin
        hw_set[evt_latch_pkg::MISSED_BIT] = 1'b1; // R13
      end
      nxt_st.synch_seen = 1'b1;
      nxt_st.seen_start = 1'b0;
      nxt_st.gap_after = 1'b0;
    end

    // Overlong cycle timer
    if (st_ff.timing_run)
    begin
      if (st_ff.cyc_cnt != 16'hFFFF)
      begin
        nxt_st.cyc_cnt = st_ff.cyc_cnt + 16'h0001;
      end
      if (src.subaction_gap)
      begin
        nxt_st.timing_run = 1'b0;
      end
    end
    if (src.cycle_start_tx && st_ff.timing_root)
    begin
      nxt_st.timing_run = 1'b1;
      nxt_st.cyc_cnt = 16'h0000;
    end
    if (st_ff.timing_run && st_ff.timing_root &&
        src.subaction_gap && st_ff.cyc_cnt > 16'(OVERLONG_LIMIT))
    begin
      hw_set[evt_latch_pkg::OVERLONG_BIT] = 1'b1; // R8
    end

    // Register writes; set wins over clear
    if (do_wr && {st_ff.awaddr[7:2], 2'b00} == evt_latch_pkg::CLEAR_PORT_OFF)
    begin
      nxt_st.events = st_ff.events &
        ~(st_ff.wdata & wr_mask & evt_latch_pkg::VALID_MASK); // R2 R18
    end
    if (do_wr && {st_ff.awaddr[7:2], 2'b00} == evt_latch_pkg::SET_PORT_OFF)
    begin
      hw_set = hw_set | (st_ff.wdata & wr_mask); // R1 R5 R18
    end
    if (do_wr && {st_ff.awaddr[7:2], 2'b00} == evt_latch_pkg::MASK_OFF)
    begin
      nxt_st.mask = ((st_ff.wdata & wr_mask) | (st_ff.mask & ~wr_mask)) &
        evt_latch_pkg::VALID_MASK;
    end
    if (do_wr && {st_ff.awaddr[7:2], 2'b00} == evt_latch_pkg::CTRL_OFF &&
        st_ff.wstrb[0])
    begin
      nxt_st.late_ack_en = st_ff.wdata[evt_latch_pkg::CTRL_LATE_ACK_BIT];
      nxt_st.timing_root = st_ff.wdata[evt_latch_pkg::CTRL_TIMING_ROOT_BIT];
    end
    if (hw_set[evt_latch_pkg::OVERLONG_BIT])
    begin
      nxt_st.timing_root = 1'b0; // R9
    end
    nxt_st.events = (nxt_st.events | hw_set) &
      evt_latch_pkg::VALID_MASK; // R1 R4

    // Read channel
    case ({s_axi_araddr[7:2], 2'b00})
      evt_latch_pkg::SET_PORT_OFF,
      evt_latch_pkg::CLEAR_PORT_OFF:
      begin
        rd_val = st_ff.events & st_ff.mask; // R3
      end
      evt_latch_pkg::MASK_OFF:
      begin
        rd_val = st_ff.mask;
      end
      evt_latch_pkg::CTRL_OFF:
      begin
        rd_val = {30'h0, st_ff.timing_root, st_ff.late_ack_en};
      end
      evt_latch_pkg::TIMER_OFF:
      begin
        rd_val = {src.seconds_field, src.period_count_field, 12'h000};
      end
      evt_latch_pkg::PHY_DATA_OFF:
      begin
        rd_val = {8'h00, st_ff.phy_byte, 16'h0000}; // R7
      end
      default:
      begin
        rd_val = 32'h0000_0000;
      end
    endcase
    nxt_st.arready = 1'b0;
    if (s_axi_arvalid && !st_ff.arready && !st_ff.rvalid)
    begin
      nxt_st.arready = 1'b1;
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd_val;
      nxt_st.rresp = (s_axi_araddr[7:2] >= 6'h20 && s_axi_araddr[7:2] <= 6'h25)
        ? evt_latch_pkg::RESP_OKAY : evt_latch_pkg::RESP_SLVERR;
    end
    if (st_ff.rvalid && s_axi_rready)
    begin
      nxt_st.rvalid = 1'b0;
    end
    nxt_st.irq = |(nxt_st.events & nxt_st.mask);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ff <= '0;
      st_ff.events <= evt_latch_pkg::EVENT_RESET; // R17
      st_ff.mask <= evt_latch_pkg::MASK_RESET;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready = st_ff.wready;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rresp = st_ff.rresp;
  assign s_axi_rdata = st_ff.rdata;
  assign irq = st_ff.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  localparam int SW = evt_latch_pkg::SOFT_BIT;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reserved_zero_a: assert property ( // R4
    st_ff.events[31:30] == 2'b00 && !st_ff.events[28])
    else $error("reserved bit set");
  clear_only_a: assert property ( // R2
    $fell(st_ff.events[SW]) |-> $past(do_wr))
    else $error("event cleared without write");
  sticky_pstart_a: assert property ( // R16
    cnt_edge |=> st_ff.events[20])
    else $error("period start lost");
  sticky_sixty_a: assert property ( // R15
    src.seconds_field[6] != st_ff.sec6_d |=> st_ff.events[21])
    else $error("64s event lost");
  read_and_a: assert property (s_axi_arvalid && !st_ff.arready && // R3
    !st_ff.rvalid && s_axi_araddr == 8'h80 |=>
    s_axi_rdata == $past(st_ff.events & st_ff.mask))
    else $error("read not masked");
  overlong_root_a: assert property (hw_set[25] |=> !st_ff.timing_root) // R9
    else $error("root not cleared");
  phy_set_a: assert property (src.phy_byte_strobe && !st_ff.phy_d |=> // R7
    st_ff.events[26] && st_ff.phy_byte == $past(src.phy_byte))
    else $error("phy byte event");
  fatal_set_a: assert property (src.context_dead && !st_ff.dead_d |=> // R10
    st_ff.events[24]) else $error("fatal stop lost");
  late_gate_a: assert property ( // R6
    !st_ff.events[27] && !st_ff.late_ack_en && !do_wr |=> !st_ff.events[27])
    else $error("late ack ungated");
  irq_level_a: assert property (irq == |(st_ff.events & st_ff.mask))
    else $error("irq mismatch");
  missed_flag_a: assert property ( // R13
    cnt_edge && st_ff.synch_seen && !st_ff.seen_start |=>
    st_ff.events[evt_latch_pkg::MISSED_BIT])
    else $error("lost cycle not flagged");
  fatal_block_a: assert property ( // R11
    blocked && !do_wr && !st_ff.events[evt_latch_pkg::LATE_BIT] |=>
    !st_ff.events[evt_latch_pkg::LATE_BIT])
    else $error("late ack not blocked");

  wr_cov_c: cover property (do_wr);
  irq_cov_c: cover property ($rose(irq));
  lost_cov_c: cover property (hw_set[22]);
  fatal_cov_c: cover property (blocked && late_src);

endmodule

// ### verification/tb_serial_bus_interrupt_event_latch.sv
`timescale 1ns/1ps
module tb_serial_bus_interrupt_event_latch;
  logic                    aclk = 1'b0;
  logic                    aresetn = 1'b0;
  logic [7:0]              awaddr = 8'h00;
  logic                    awvalid = 1'b0;
  logic                    awready;
  logic [31:0]             wdata = 32'h0;
  logic [3:0]              wstrb = 4'hF;
  logic                    wvalid = 1'b0;
  logic                    wready;
  logic [1:0]              bresp;
  logic                    bvalid;
  logic                    bready = 1'b0;
  logic [7:0]              araddr = 8'h00;
  logic                    arvalid = 1'b0;
  logic                    arready;
  logic [31:0]             rdata;
  logic [1:0]              rresp;
  logic                    rvalid;
  logic                    rready = 1'b0;
  evt_latch_pkg::evt_src_t src = '0;
  logic                    irq;
  int                      n_errors = 0;
  int                      total_checks = 0;
  logic [31:0]             d;
  logic [1:0]              r;

  always #25 aclk = ~aclk;

  serial_bus_interrupt_event_latch #(.OVERLONG_LIMIT(20)) dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .src(src), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] b(input int n);
    return 32'h1 << n;
  endfunction

  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask

  task automatic close_out;
    if (n_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Ready sampled at negedge, acted on at the following posedge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge aclk);
      ta = (awready === 1'b1);
      tw = (wready === 1'b1);
      tb = (bvalid === 1'b1);
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    logic tr, ta;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr)
    begin
      @(negedge aclk);
      tr = (rvalid === 1'b1);
      ta = (arready === 1'b1);
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  task automatic clr_all;
    wr(evt_latch_pkg::CLEAR_PORT_OFF, 32'hFFFF_FFFF);
  endtask

  task automatic ev(input int n, input logic e);
    rd(evt_latch_pkg::SET_PORT_OFF);
    chk("event bit", d & b(n), e ? b(n) : 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(evt_latch_pkg::MASK_OFF);
    chk("mask reset", d, 32'h0);
    wr(evt_latch_pkg::MASK_OFF, 32'hFFFF_FFFF);
    rd(evt_latch_pkg::SET_PORT_OFF);
    chk("event reset", d, 32'h0);
    chk("irq reset", {31'h0, irq}, 32'h0);
  endtask

  task automatic t_set_clear;
    wr(evt_latch_pkg::SET_PORT_OFF, 32'hFFFF_FFFF);
    rd(evt_latch_pkg::SET_PORT_OFF);
    chk("set all", d, evt_latch_pkg::VALID_MASK);
    chk("irq set", {31'h0, irq}, 32'h1);
    wr(evt_latch_pkg::CLEAR_PORT_OFF, 32'h0);
    rd(evt_latch_pkg::CLEAR_PORT_OFF);
    chk("zero write", d, evt_latch_pkg::VALID_MASK);
    wr(evt_latch_pkg::MASK_OFF, b(29));
    rd(evt_latch_pkg::CLEAR_PORT_OFF);
    chk("masked read", d, b(29));
    wr(evt_latch_pkg::CLEAR_PORT_OFF, b(29));
    rd(evt_latch_pkg::SET_PORT_OFF);
    chk("soft clear", d, 32'h0);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(evt_latch_pkg::MASK_OFF, 32'hFFFF_FFFF);
    rd(evt_latch_pkg::SET_PORT_OFF);
    chk("others kept", d, evt_latch_pkg::VALID_MASK & ~b(29));
    clr_all();
    wstrb <= 4'h4;
    wr(evt_latch_pkg::SET_PORT_OFF, 32'hFFFF_FFFF);
    wstrb <= 4'hF;
    rd(evt_latch_pkg::SET_PORT_OFF);
    chk("strobe lanes", d, 32'h00F0_0000);
    clr_all();
  endtask

  task automatic t_sources;
    src.phy_byte <= 8'hA5;
    src.phy_byte_strobe <= 1'b1;
    @(posedge aclk);
    src.phy_byte_strobe <= 1'b0;
    ev(evt_latch_pkg::PHY_BIT, 1'b1);
    rd(evt_latch_pkg::PHY_DATA_OFF);
    chk("phy byte", d & 32'h00FF_0000, 32'h00A5_0000);
    src.period_count_field <= 13'h1;
    ev(evt_latch_pkg::PSTART_BIT, 1'b1);
    src.seconds_field <= 7'h40;
    ev(evt_latch_pkg::SIXTYFOUR_BIT, 1'b1);
    src.rx_seconds <= 7'h00;
    src.rx_count <= 13'h1;
    src.cycle_start_rx <= 1'b1;
    @(posedge aclk);
    src.cycle_start_rx <= 1'b0;
    ev(evt_latch_pkg::MISMATCH_BIT, 1'b1);
    clr_all();
  endtask

  task automatic t_fatal;
    wr(evt_latch_pkg::CTRL_OFF, 32'h1);
    src.context_dead <= 1'b1;
    @(posedge aclk);
    src.context_dead <= 1'b0;
    ev(evt_latch_pkg::FATAL_BIT, 1'b1);
    src.rx_fifo_pending <= 1'b1;
    ev(evt_latch_pkg::LATE_BIT, 1'b0);
    src.rx_fifo_pending <= 1'b0;
    wr(evt_latch_pkg::CLEAR_PORT_OFF, b(24));
    src.phys_resp_busy <= 1'b1;
    ev(evt_latch_pkg::LATE_BIT, 1'b1);
    src.phys_resp_busy <= 1'b0;
    wr(evt_latch_pkg::CTRL_OFF, 32'h0);
    clr_all();
    src.late_ack_sent <= 1'b1;
    ev(evt_latch_pkg::LATE_BIT, 1'b0);
    src.late_ack_sent <= 1'b0;
  endtask

  task automatic t_overlong;
    wr(evt_latch_pkg::CTRL_OFF, 32'h2);
    src.cycle_start_tx <= 1'b1;
    @(posedge aclk);
    src.cycle_start_tx <= 1'b0;
    repeat (30) @(posedge aclk);
    src.subaction_gap <= 1'b1;
    @(posedge aclk);
    src.subaction_gap <= 1'b0;
    ev(evt_latch_pkg::OVERLONG_BIT, 1'b1);
    rd(evt_latch_pkg::CTRL_OFF);
    chk("root cleared", d & 32'h2, 32'h0);
    clr_all();
  endtask

  task automatic t_lost;
    src.period_count_field <= 13'h2;
    @(posedge aclk);
    ev(evt_latch_pkg::MISSED_BIT, 1'b0);
    src.period_count_field <= 13'h3;
    @(posedge aclk);
    ev(evt_latch_pkg::MISSED_BIT, 1'b1);
    clr_all();
    src.arb_reset_gap <= 1'b1;
    @(posedge aclk);
    src.arb_reset_gap <= 1'b0;
    ev(evt_latch_pkg::MISSED_BIT, 1'b1);
    clr_all();
  endtask

  task automatic t_unmapped;
    rd(8'hF0);
    chk("bad read resp", {30'h0, r}, {30'h0, evt_latch_pkg::RESP_SLVERR});
    chk("bad read data", d, 32'h0);
    wr(8'hF0, 32'hFFFF_FFFF);
    chk("bad write resp", {30'h0, r}, {30'h0, evt_latch_pkg::RESP_SLVERR});
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    close_out();
  end

  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_set_clear();
    t_sources();
    t_fatal();
    t_overlong();
    t_lost();
    t_unmapped();
    close_out();
  end
endmodule
